// ---- design/iat_cfg.svh ----
// Purpose: offsets, field positions, reset values and timing of the indirect/tone block
// Assumes: byte-wide registers at their printed offsets
// Notes:   definitions only
`ifndef IAT_CFG_SVH
`define IAT_CFG_SVH

// register offsets
`define IAT_OFS_IRQ_STATUS3    8'h14
`define IAT_OFS_TONE_STATUS    8'h18
`define IAT_OFS_WORD_LOW       8'h1c
`define IAT_OFS_WORD_HIGH      8'h1d
`define IAT_OFS_LOCATION       8'h1e
`define IAT_OFS_PENDING        8'h1f

// field positions
`define IAT_BIT_TONE_PRESENT   4
`define IAT_BIT_PENDING        0
`define IAT_BIT_TONE_IRQ       0
`define IAT_BIT_DONE_IRQ       1

// reset values
`define IAT_RST_TONE_STATUS    8'h00
`define IAT_RST_WORD_LOW       8'h00
`define IAT_RST_WORD_HIGH      8'h00
`define IAT_RST_LOCATION       8'h00

// timing
`define IAT_CLK_HZ             250000000
`define IAT_UPDATE_HZ          16000

`endif

// ---- design/iat_pkg.sv ----
// Purpose: shared types of the indirect/tone block
// Assumes: nothing
// Notes:   numbers live in iat_cfg.svh
package iat_pkg;

	// outstanding indirect transfer
	typedef enum logic [1:0]
	{
		IAT_IDLE,
		IAT_WRITE_PEND,
		IAT_READ_PEND
	} iat_xfer_t;

	typedef logic [7:0]  iat_byte_t;
	typedef logic [15:0] iat_word_t;

endpackage : iat_pkg

// ---- design/iat_tick_if.sv ----
// Purpose: carries the periodic indirect update tick
// Assumes: single clock domain
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

interface iat_tick_if;
	logic tick;

	modport gen (output tick);
	modport use_tick (input tick);
endinterface : iat_tick_if

`default_nettype wire

// ---- design/iat_tick_gen.sv ----
// Purpose: divides core_clk down to the indirect update rate
// Assumes: ce freezes the count
// Notes:   one-cycle tick every PERIOD_CYCLES enabled cycles
`timescale 1ns/1ps
`default_nettype none

module iat_tick_gen
	import iat_pkg::*;
#(
	parameter int PERIOD_CYCLES = 15625
)
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic ce,
	// tick out
	iat_tick_if.gen   tk
);

	localparam int CW = $clog2(PERIOD_CYCLES);

	// a period below two cycles cannot be counted
	if (PERIOD_CYCLES < 2)
	begin : g_bad_period
		$error("iat_tick_gen: PERIOD_CYCLES must be at least 2");
	end

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	wire           wrap = (cnt_reg == CW'(PERIOD_CYCLES - 1));

	// counter with wrap
	assign cnt_next = wrap ? '0 : cnt_reg + CW'(1);
	assign tk.tick  = wrap & ce;

	// period counter
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_reg <= '0;
		else if (ce)
			cnt_reg <= cnt_next;
	end

endmodule : iat_tick_gen

`default_nettype wire

// ---- design/iat_regs.sv ----
// Purpose: indirect access window and tone decode status registers
// Assumes: host register port decoded from the control serial port, same clock
// Notes:   indirect array sits outside; its read data is valid while ind_req is high
`timescale 1ns/1ps
`include "iat_cfg.svh"
`default_nettype none

module iat_regs
	import iat_pkg::*;
#(
	parameter int UPDATE_CYCLES = `IAT_CLK_HZ / `IAT_UPDATE_HZ
)
(
	// clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// host register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	// tone detector
	input  wire logic        tone_present_flag,
	input  wire logic [3:0]  key_code,
	// indirect array
	output logic             ind_req,
	output logic             ind_we,
	output logic      [7:0]  ind_addr,
	output logic      [15:0] ind_wdata,
	input  wire logic [15:0] ind_rdata,
	// event flags
	output logic             indirect_done_irq,
	output logic             tone_detect_irq
);

	if (UPDATE_CYCLES < 2)
	begin : g_bad_update
		$error("iat_regs: UPDATE_CYCLES must be at least 2");
	end

	iat_tick_if tk ();

	iat_tick_gen #(
		.PERIOD_CYCLES (UPDATE_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.ce       (ce),
		.tk       (tk)
	);

	iat_byte_t tone_status_reg;
	iat_byte_t word_low_reg;
	iat_byte_t word_high_reg;
	iat_byte_t location_reg;
	iat_xfer_t xfer_reg;
	iat_xfer_t xfer_next;
	logic      data_seen_reg;
	logic      tone_prev_reg;
	logic      done_irq_reg;
	logic      tone_irq_reg;
	iat_byte_t rdata_reg;
	logic      rvalid_reg;

	// write strobes, transfer service and tone edge terms
	wire en          = ce;
	wire wr_low      = en & reg_wr & (reg_addr == `IAT_OFS_WORD_LOW);
	wire wr_high     = en & reg_wr & (reg_addr == `IAT_OFS_WORD_HIGH);
	wire wr_loc      = en & reg_wr & (reg_addr == `IAT_OFS_LOCATION);
	wire wr_irq      = en & reg_wr & (reg_addr == `IAT_OFS_IRQ_STATUS3);
	wire pending     = (xfer_reg != IAT_IDLE);
	wire service     = tk.tick & pending;
	wire svc_read    = service & (xfer_reg == IAT_READ_PEND);
	wire tone_rise   = tone_present_flag & ~tone_prev_reg;
	wire clr_done    = wr_irq & reg_wdata[`IAT_BIT_DONE_IRQ];
	wire clr_tone    = wr_irq & reg_wdata[`IAT_BIT_TONE_IRQ];

	// array access only on the service tick
	assign ind_req   = service;
	assign ind_we    = service & (xfer_reg == IAT_WRITE_PEND);
	assign ind_addr  = location_reg;
	assign ind_wdata = {word_high_reg, word_low_reg};

	// transfer state: a location write picks write or read, a tick retires it
	always_comb
	begin
		xfer_next = xfer_reg;
		if (service)
			xfer_next = IAT_IDLE;
		if (wr_loc)
			xfer_next = data_seen_reg ? IAT_WRITE_PEND : IAT_READ_PEND;
	end

	// readback mux
	iat_byte_t rd_mux;
	always_comb
	begin
		rd_mux = 8'h00;
		unique case (reg_addr)
			`IAT_OFS_IRQ_STATUS3: rd_mux = {6'h00, done_irq_reg, tone_irq_reg};
			`IAT_OFS_TONE_STATUS: rd_mux = tone_status_reg;
			`IAT_OFS_WORD_LOW:    rd_mux = word_low_reg;
			`IAT_OFS_WORD_HIGH:   rd_mux = word_high_reg;
			`IAT_OFS_LOCATION:    rd_mux = location_reg;
			`IAT_OFS_PENDING:     rd_mux = {7'h00, pending};
			default:              rd_mux = 8'h00;
		endcase
	end

	// tone status capture and edge history
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tone_status_reg <= `IAT_RST_TONE_STATUS;
			tone_prev_reg   <= 1'b0;
		end
		else if (en)
		begin
			tone_status_reg <= {3'h0, tone_present_flag, key_code};
			tone_prev_reg   <= tone_present_flag;
		end
	end

	// indirect word bytes: host writes, read transfer loads
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			word_low_reg  <= `IAT_RST_WORD_LOW;
			word_high_reg <= `IAT_RST_WORD_HIGH;
		end
		else if (svc_read)
		begin
			word_low_reg  <= ind_rdata[7:0];
			word_high_reg <= ind_rdata[15:8];
		end
		else
		begin
			if (wr_low)
				word_low_reg <= reg_wdata;
			if (wr_high)
				word_high_reg <= reg_wdata;
		end
	end

	// location, transfer state and data-written marker
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			location_reg  <= `IAT_RST_LOCATION;
			xfer_reg      <= IAT_IDLE;
			data_seen_reg <= 1'b0;
		end
		else if (en)
		begin
			xfer_reg <= xfer_next;
			if (wr_loc)
				location_reg <= reg_wdata;
			if (wr_loc)
				data_seen_reg <= 1'b0;
			else if (wr_low | wr_high)
				data_seen_reg <= 1'b1;
		end
	end

	// sticky event flags, set wins over a write-one clear
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			done_irq_reg <= 1'b0;
			tone_irq_reg <= 1'b0;
		end
		else if (en)
		begin
			done_irq_reg <= service | (done_irq_reg & ~clr_done);
			tone_irq_reg <= tone_rise | (tone_irq_reg & ~clr_tone);
		end
	end

	// registered read data, one cycle after reg_rd
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else if (en)
		begin
			rvalid_reg <= reg_rd;
			if (reg_rd)
				rdata_reg <= rd_mux;
		end
	end

	assign reg_rdata         = rdata_reg;
	assign reg_rvalid        = rvalid_reg;
	assign indirect_done_irq = done_irq_reg;
	assign tone_detect_irq   = tone_irq_reg;

endmodule : iat_regs

`default_nettype wire

// ---- test/iat_checker.sv ----
// Purpose: port checks of iat_regs
// Assumes: assertions pause while ce is low
// Notes:   bound below
`timescale 1ns/1ps
`default_nettype none
module iat_checker #(parameter int UPDATE_CYCLES = 8)
(
	// clock, reset
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       ce,
	// host port
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	// detector, array, flags
	input wire logic       tone_present_flag,
	input wire logic [3:0] key_code,
	input wire logic       ind_req,
	input wire logic       ind_we,
	input wire logic       indirect_done_irq,
	input wire logic       tone_detect_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n || !ce);
	logic pend_seen_reg;
	// pending shadow: a location write arms it, an array access retires it
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pend_seen_reg <= 1'b0;
		else if (ce)
			pend_seen_reg <= (reg_wr && reg_addr == 8'h1e) || (pend_seen_reg && !ind_req);
	end
	// transfer timing, flags and status reads
	property p_serve; reg_wr && reg_addr == 8'h1e |-> ##[0:UPDATE_CYCLES] ind_req; endproperty
	a_serve: assert property (p_serve) else $error("transfer not served");
	property p_pulse; ind_req |=> !ind_req; endproperty
	a_pulse: assert property (p_pulse) else $error("access longer than a cycle");
	property p_we; ind_we |-> ind_req; endproperty
	a_we: assert property (p_we) else $error("write strobe outside access");
	property p_done; ind_req |=> indirect_done_irq; endproperty
	a_done: assert property (p_done) else $error("done flag not set");
	property p_clr; reg_wr && reg_addr == 8'h14 && reg_wdata[1] && !ind_req |=> !indirect_done_irq; endproperty
	a_clr: assert property (p_clr) else $error("done flag not cleared");
	property p_tirq; $rose(tone_present_flag) |-> ##[1:2] tone_detect_irq; endproperty
	a_tirq: assert property (p_tirq) else $error("tone flag not set");
	property p_tone; reg_rvalid && $past(reg_addr) == 8'h18 |->
		reg_rdata == {3'h0, $past(tone_present_flag, 2), $past(key_code, 2)}; endproperty
	a_tone: assert property (p_tone) else $error("tone status wrong");
	property p_pend; reg_rvalid && $past(reg_addr) == 8'h1f |->
		reg_rdata == {7'h00, $past(pend_seen_reg)}; endproperty
	a_pend: assert property (p_pend) else $error("pending status wrong");
endmodule : iat_checker
bind iat_regs iat_checker #(.UPDATE_CYCLES(UPDATE_CYCLES)) iat_checker_i (.core_clk, .arst_n,
	.reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .tone_present_flag, .key_code,
	.ind_req, .ind_we, .indirect_done_irq, .tone_detect_irq, .ce);
`default_nettype wire

// ---- test/tb_indirect_access_and_tone_status.sv ----
// Purpose: self-checking bench of iat_regs
// Assumes: indirect array modelled here, ce high but for one freeze test
// Notes:   update every 8 cycles, seed 82
`timescale 1ns/1ps
`default_nettype none
module tb_indirect_access_and_tone_status;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        ce = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        tone_present_flag = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [3:0]  key_code = 4'h0;
	logic [7:0]  reg_rdata, ind_addr, a;
	logic        reg_rvalid, ind_req, ind_we, indirect_done_irq, tone_detect_irq;
	logic [15:0] ind_wdata, ind_rdata, got, w;
	logic [15:0] mem [256];
	int          n_mismatch = 0;
	int          num_checks = 0;
	// clock and indirect array
	always #2 core_clk = ~core_clk;
	assign ind_rdata = mem[ind_addr];
	always @(posedge core_clk) if (ind_req && ind_we) mem[ind_addr] <= ind_wdata;
	iat_regs #(.UPDATE_CYCLES(8)) iat_regs_i (.core_clk, .arst_n, .ce, .reg_addr,
		.reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .tone_present_flag, .key_code,
		.ind_req, .ind_we, .ind_addr, .ind_wdata, .ind_rdata, .indirect_done_irq,
		.tone_detect_irq);
	function automatic logic [15:0] tone_exp(logic f, logic [3:0] k);
		return {11'h000, f, k};
	endfunction : tone_exp
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task automatic chk(logic [15:0] g, logic [15:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// one strobe cycle, then an idle cycle
	task automatic wr(logic [7:0] ad, logic [7:0] d);
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		@(negedge core_clk);
	endtask : wr
	task automatic rd(logic [7:0] ad);
		reg_addr = ad;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk({15'h0, reg_rvalid}, 16'h1);
		got = {8'h00, reg_rdata};
		@(negedge core_clk);
	endtask : rd
	task automatic wait_idle;
		for (int i = 0; i < 20; i++)
		begin
			rd(8'h1f);
			if (got[0] === 1'b0) return;
		end
		n_mismatch++;
		close_out;
	endtask : wait_idle
	initial
	begin
		void'($urandom(82));
		foreach (mem[i]) mem[i] = 16'($urandom);
		repeat (6) @(negedge core_clk);
		arst_n = 1'b1;
		// reset values, read-only and unmapped places
		rd(8'h18);
		chk(got, 16'h0000);
		rd(8'h1c);
		chk(got, 16'h0000);
		wr(8'h18, 8'hff);
		rd(8'h18);
		chk(got, 16'h0000);
		rd(8'h40);
		chk(got, 16'h0000);
		$display("reset test done");
		// clock enable low: a byte write and a tone burst are frozen out
		ce = 1'b0;
		tone_present_flag = 1'b1;
		key_code = 4'h7;
		wr(8'h1c, 8'h5a);
		tone_present_flag = 1'b0;
		key_code = 4'h0;
		@(negedge core_clk);
		ce = 1'b1;
		rd(8'h1c);
		chk(got, 16'h0000);
		rd(8'h18);
		chk(got, 16'h0000);
		chk({15'h0, tone_detect_irq}, 16'h0);
		$display("enable test done");
		// write transfer then read transfer at random places
		repeat (6)
		begin
			a = 8'($urandom);
			w = 16'($urandom);
			wr(8'h1c, w[7:0]);
			wr(8'h1d, w[15:8]);
			wr(8'h1e, a);
			wait_idle;
			chk(mem[a], w);
			chk({15'h0, indirect_done_irq}, 16'h1);
			rd(8'h14);
			chk(got, 16'h0002);
			wr(8'h14, 8'h02);
			chk({15'h0, indirect_done_irq}, 16'h0);
			a = a + 8'h01;
			wr(8'h1e, a);
			wait_idle;
			rd(8'h1c);
			chk(got, {8'h00, mem[a][7:0]});
			rd(8'h1d);
			chk(got, {8'h00, mem[a][15:8]});
			rd(8'h1e);
			chk(got, {8'h00, a});
			chk({15'h0, indirect_done_irq}, 16'h1);
			wr(8'h14, 8'h02);
		end
		$display("indirect test done");
		// every key code, present then gone
		for (int k = 0; k < 16; k++)
		begin
			tone_present_flag = 1'b1;
			key_code = 4'(k);
			repeat (3) @(negedge core_clk);
			rd(8'h18);
			chk(got, tone_exp(1'b1, 4'(k)));
			chk({15'h0, tone_detect_irq}, 16'h1);
			rd(8'h14);
			chk(got, 16'h0001);
			wr(8'h14, 8'h01);
			tone_present_flag = 1'b0;
			repeat (3) @(negedge core_clk);
			rd(8'h18);
			chk(got, tone_exp(1'b0, 4'(k)));
			chk({15'h0, tone_detect_irq}, 16'h0);
		end
		$display("tone test done");
		close_out;
	end
endmodule : tb_indirect_access_and_tone_status
`default_nettype wire
